// [src/spfis_pkg.sv]
// package: register map, flag positions and carrier types of the port event block
package spfis_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_FRAME_BASE  = 12'h000;
  localparam logic [11:0] OFS_EVENT_FLAGS = 12'h004;
  localparam logic [11:0] OFS_EVENT_ENAB  = 12'h008;
  localparam logic [11:0] OFS_PORT_CTRL   = 12'h00c;
  localparam logic [11:0] OFS_GLOBAL_CTRL = 12'h010;
  localparam logic [11:0] OFS_PORT_STAT   = 12'h014;

  // frame area geometry
  localparam int          BASE_LSB        = 8;
  localparam int          FRAME_AREA_BYTES = 256;
  localparam int          UNK_FRAME_MAX   = 64;

  // flag bit positions
  localparam int BIT_COLD   = 31;
  localparam int BIT_TFERR  = 30;
  localparam int BIT_HBFAT  = 29;
  localparam int BIT_HBDAT  = 28;
  localparam int BIT_IFFAT  = 27;
  localparam int BIT_IFNF   = 26;
  localparam int BIT_OVFL   = 24;
  localparam int BIT_PMM    = 23;
  localparam int BIT_PRDY   = 22;
  localparam int BIT_CONN   = 6;
  localparam int BIT_DPROC  = 5;
  localparam int BIT_UNK    = 4;
  localparam int BIT_SDB    = 3;
  localparam int BIT_DSET   = 2;
  localparam int BIT_PSET   = 1;
  localparam int BIT_D2H    = 0;

  // flags that software clears by writing one
  localparam logic [31:0] W1C_MASK  = 32'hed80002f;
  // flags that mirror diagnostic bits elsewhere
  localparam logic [31:0] MIRROR_MASK = 32'h00400050;
  // bits that hold state at all
  localparam logic [31:0] LIVE_MASK = 32'hfdc0007f;

  localparam logic [31:0] RST_WORD  = 32'h00000000;
  localparam logic        RST_BIT   = 1'b0;

  // transport, link and DMA events, one-cycle pulses
  typedef struct packed {
    logic       presence_toggle;
    logic       taskfile_update;
    logic [7:0] taskfile_status;
    logic       bus_error_resp;
    logic       sync_escape_tx;
    logic       data_frame_err;
    logic       nondata_frame_err;
    logic       unknown_frame_good;
    logic [7:0] unknown_frame_len;
    logic       unknown_frame_posted;
    logic       prd_zero_count;
    logic       prd_underflow;
    logic       prd_overflow;
    logic       pm_field_mismatch;
    logic       d2h_irq_posted;
    logic       sdb_irq_posted;
    logic       dma_setup_irq_posted;
    logic       pio_setup_irq_posted;
    logic       prd_irq_done;
  } spfis_evt_t;

  // diagnostic levels mirrored from the port error register
  typedef struct packed {
    logic phy_ready_change_diag;
    logic connect_change_diag;
    logic unknown_frame_diag;
  } spfis_diag_t;

  // APB request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } spfis_apb_req_t;

endpackage

// [src/spfis_flag_bit.sv]
// file holds one sticky write-one-to-clear event flag
`timescale 1ns/10ps
`default_nettype none

module spfis_flag_bit (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output logic      flag
);

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag <= spfis_pkg::RST_BIT;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_req) begin
      flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [src/spfis_port_events.sv]
// file holds the received-frame base and port event flag registers with APB access
// Behaviour
// (R1) frame base bits 31:8 writable, low byte zero
// (R2) frame area is a 256-byte aligned structure
// (R3) events set flags, writing one clears
// (R4) any set flag sources the interrupt
// (R5) reset clears every flag; bits 22 and 6 are not reset and follow the diagnostic mirrors
// (R6) presence toggle sets bit 31 if capable
// (R7) taskfile update with error sets bit 30
// (R8) bus error response sets bit 29
// (R9) bit 28 always reads zero
// (R10) sync escape while transmitting sets 27
// (R11) data frame link errors set 27
// (R12) long good-crc unknown frame sets 27
// (R13) zero descriptor byte count sets 27
// (R14) fatal errors freeze DMA until released
// (R15) non-data frame errors set bit 26
// (R16) descriptor underflow on read sets 26
// (R17) non-fatal error: resend frame, keep running
// (R18) descriptor overflow sets bit 24
// (R19) port multiplier mismatch sets bit 23
// (R20) software ignores mismatch during enumeration
// (R21) bit 22 mirrors phy ready diagnostic
// (R22) interrupt needs flag, enable, global enable
// (R23) bit 6 mirrors connect diagnostic
// (R24) bit 4 set on posting, cleared by diagnostic
// (R25) d2h register frame with irq sets 0
// (R26) reserved bits read zero, ignore writes
// (R27) flags sticky, new event beats clear
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module spfis_port_events #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESET_N,
  // apb slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [ADDR_W-1:0]     PADDR,
  input  wire logic [31:0]           PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // port events and diagnostics
  input  wire spfis_pkg::spfis_evt_t EVT,
  input  wire spfis_pkg::spfis_diag_t DIAG,
  input  wire logic                  PRESENCE_PIN,
  input  wire logic                  PORT_RESET,
  // port side outputs
  output logic [31:0]                FRAME_AREA_BASE,
  output logic [31:0]                FRAME_AREA_END,
  output logic                       DMA_FATAL,
  output logic                       FRAME_RESEND,
  output logic                       PORT_START,
  output logic                       INTRQ
);

  // ===========================================================
  // elaboration checks
  // the decode needs five address bits to reach the status offset
  if (ADDR_W < 5) begin : g_addr_w_check
    $error("address width too small for register map");
  end

  // ===========================================================
  // apb decode
  logic                 wr_acc;
  logic                 rd_acc;
  logic [ADDR_W-1:0]    a_frame_base;
  logic [ADDR_W-1:0]    a_flags;
  logic [ADDR_W-1:0]    a_enab;
  logic [ADDR_W-1:0]    a_pctl;
  logic [ADDR_W-1:0]    a_gctl;
  logic [ADDR_W-1:0]    a_pstat;
  logic                 hit;
  logic [31:0]          wmask;

  assign a_frame_base = ADDR_W'(spfis_pkg::OFS_FRAME_BASE);
  assign a_flags      = ADDR_W'(spfis_pkg::OFS_EVENT_FLAGS);
  assign a_enab       = ADDR_W'(spfis_pkg::OFS_EVENT_ENAB);
  assign a_pctl       = ADDR_W'(spfis_pkg::OFS_PORT_CTRL);
  assign a_gctl       = ADDR_W'(spfis_pkg::OFS_GLOBAL_CTRL);
  assign a_pstat      = ADDR_W'(spfis_pkg::OFS_PORT_STAT);

  // zero-wait slave: every access completes in its first access cycle
  assign PREADY  = 1'b1;
  assign hit     = (PADDR == a_frame_base) || (PADDR == a_flags) || (PADDR == a_enab)
                || (PADDR == a_pctl) || (PADDR == a_gctl) || (PADDR == a_pstat);
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign wr_acc  = PSEL && PENABLE && PWRITE && hit;
  assign rd_acc  = PSEL && !PENABLE && !PWRITE;
  assign wmask   = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};

  // ===========================================================
  // received-frame base register
  logic [31:0] frame_base_r;

  // (R1) low byte held at zero
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      frame_base_r <= spfis_pkg::RST_WORD;
    end else if (wr_acc && PADDR == a_frame_base) begin
      frame_base_r[31:spfis_pkg::BASE_LSB] <=
        (frame_base_r[31:spfis_pkg::BASE_LSB] & ~wmask[31:spfis_pkg::BASE_LSB])
        | (PWDATA[31:spfis_pkg::BASE_LSB] & wmask[31:spfis_pkg::BASE_LSB]);
    end
  end

  // (R2) area span exported
  assign FRAME_AREA_BASE = {frame_base_r[31:spfis_pkg::BASE_LSB], 8'h00};
  assign FRAME_AREA_END  = FRAME_AREA_BASE + 32'(spfis_pkg::FRAME_AREA_BYTES - 1);

  // ===========================================================
  // control registers: enables, port start, cold detect capability, global enable
  logic [31:0] enab_r;
  logic        port_start_r;
  logic        cold_detect_capability_r;
  logic        global_irq_enable_r;

  // enable register mirrors the live flag layout
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      enab_r <= spfis_pkg::RST_WORD;
    end else if (wr_acc && PADDR == a_enab) begin
      enab_r <= ((enab_r & ~wmask) | (PWDATA & wmask)) & spfis_pkg::LIVE_MASK;
    end
  end

  // port control: bit 0 start, bit 1 cold detect capability
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      port_start_r             <= spfis_pkg::RST_BIT;
      cold_detect_capability_r <= spfis_pkg::RST_BIT;
    end else if (wr_acc && PADDR == a_pctl && PSTRB[0]) begin
      port_start_r             <= PWDATA[0];
      cold_detect_capability_r <= PWDATA[1];
    end
  end

  // global control: bit 1 interrupt enable
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      global_irq_enable_r <= spfis_pkg::RST_BIT;
    end else if (wr_acc && PADDR == a_gctl && PSTRB[0]) begin
      global_irq_enable_r <= PWDATA[1];
    end
  end

  assign PORT_START = port_start_r;

  // ===========================================================
  // presence pin synchroniser and toggle detect
  logic pres_s1_r;
  logic pres_s2_r;
  logic pres_s3_r;

  // two stages before use, third for edge detect
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      pres_s1_r <= spfis_pkg::RST_BIT;
      pres_s2_r <= spfis_pkg::RST_BIT;
      pres_s3_r <= spfis_pkg::RST_BIT;
    end else begin
      pres_s1_r <= PRESENCE_PIN;
      pres_s2_r <= pres_s1_r;
      pres_s3_r <= pres_s2_r;
    end
  end

  // presence input was synchronised once at the first edge after reset
  logic pres_armed_r;
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      pres_armed_r <= 1'b0;
    end else begin
      pres_armed_r <= 1'b1;
    end
  end

  // ===========================================================
  // event set vector
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] flags;

  always_comb begin
    set_vec = '0;
    // (R6) pin toggle, gated by capability
    set_vec[spfis_pkg::BIT_COLD]  = cold_detect_capability_r && pres_armed_r
                                 && ((pres_s2_r ^ pres_s3_r) || EVT.presence_toggle);
    // (R7) error bit of status byte
    set_vec[spfis_pkg::BIT_TFERR] = EVT.taskfile_update && EVT.taskfile_status[0];
    // (R8) master error response
    set_vec[spfis_pkg::BIT_HBFAT] = EVT.bus_error_resp;
    // (R10) escape during transmit
    // (R11) data frame link errors
    // (R12) oversize unknown frame
    // (R13) zero descriptor count
    set_vec[spfis_pkg::BIT_IFFAT] = EVT.sync_escape_tx || EVT.data_frame_err
                                 || (EVT.unknown_frame_good
                                     && EVT.unknown_frame_len > 8'(spfis_pkg::UNK_FRAME_MAX))
                                 || EVT.prd_zero_count;
    // (R15) non-data frame errors
    // (R16) descriptor underflow
    set_vec[spfis_pkg::BIT_IFNF]  = EVT.nondata_frame_err || EVT.prd_underflow;
    // (R18) descriptor overflow
    set_vec[spfis_pkg::BIT_OVFL]  = EVT.prd_overflow;
    // (R19) multiplier field mismatch
    set_vec[spfis_pkg::BIT_PMM]   = EVT.pm_field_mismatch;
    set_vec[spfis_pkg::BIT_DPROC] = EVT.prd_irq_done;
    set_vec[spfis_pkg::BIT_SDB]   = EVT.sdb_irq_posted;
    set_vec[spfis_pkg::BIT_DSET]  = EVT.dma_setup_irq_posted;
    set_vec[spfis_pkg::BIT_PSET]  = EVT.pio_setup_irq_posted;
    // (R25) register frame posted
    set_vec[spfis_pkg::BIT_D2H]   = EVT.d2h_irq_posted;
  end

  // (R3) write one clears, zero keeps
  assign clr_vec = (wr_acc && PADDR == a_flags) ? (PWDATA & wmask & spfis_pkg::W1C_MASK)
                                                : 32'h00000000;

  // ===========================================================
  // sticky flags, one cell per write-one-to-clear position
  // (R27) sticky, set beats clear
  // (R5) reset clears flags
  for (genvar i = 0; i < 32; i++) begin : g_flag
    if (spfis_pkg::W1C_MASK[i]) begin : g_w1c
      spfis_flag_bit u_bit (
        .clk     (SYS_CLK),
        .rst_n   (RESET_N),
        .set_evt (set_vec[i]),
        .clr_req (clr_vec[i]),
        .flag    (flags[i])
      );
    end else if (!spfis_pkg::MIRROR_MASK[i]) begin : g_zero
      // (R26) reserved reads zero
      // (R9) bus data flag stays zero
      assign flags[i] = 1'b0;
    end
  end

  // (R21) mirror of phy ready diagnostic
  assign flags[spfis_pkg::BIT_PRDY] = DIAG.phy_ready_change_diag;
  // (R23) mirror of connect diagnostic
  assign flags[spfis_pkg::BIT_CONN] = DIAG.connect_change_diag;

  // unknown frame flag: set on posting, cleared with the diagnostic
  logic unk_r;
  // (R24) posting sets, diagnostic low clears
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      unk_r <= spfis_pkg::RST_BIT;
    end else if (EVT.unknown_frame_posted) begin
      unk_r <= 1'b1;
    end else if (!DIAG.unknown_frame_diag) begin
      unk_r <= 1'b0;
    end
  end
  assign flags[spfis_pkg::BIT_UNK] = unk_r;

  // ===========================================================
  // dma fatal hold and non-fatal resend
  logic fatal_r;
  logic resend_r;

  // (R14) freeze until start cleared or reset
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N || PORT_RESET) begin
      fatal_r <= spfis_pkg::RST_BIT;
    end else if (set_vec[spfis_pkg::BIT_IFFAT] || set_vec[spfis_pkg::BIT_OVFL]) begin
      fatal_r <= 1'b1;
    end else if (!port_start_r) begin
      fatal_r <= 1'b0;
    end
  end

  // (R17) resend failed non-data frame
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N || PORT_RESET) begin
      resend_r <= spfis_pkg::RST_BIT;
    end else if (EVT.nondata_frame_err) begin
      resend_r <= 1'b1;
    end else begin
      resend_r <= 1'b0;
    end
  end

  assign DMA_FATAL    = fatal_r;
  assign FRAME_RESEND = resend_r;

  // ===========================================================
  // interrupt output
  logic intrq_r;

  // (R4) any enabled flag sources it
  // (R22) flag, enable and global enable
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      intrq_r <= spfis_pkg::RST_BIT;
    end else begin
      intrq_r <= global_irq_enable_r && |(flags & enab_r);
    end
  end
  assign INTRQ = intrq_r;

  // ===========================================================
  // read data, captured in the setup cycle
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (PADDR == a_frame_base) begin
      rdata_nxt = FRAME_AREA_BASE;
    end else if (PADDR == a_flags) begin
      rdata_nxt = flags & spfis_pkg::LIVE_MASK;
    end else if (PADDR == a_enab) begin
      rdata_nxt = enab_r;
    end else if (PADDR == a_pctl) begin
      rdata_nxt = {30'h0, cold_detect_capability_r, port_start_r};
    end else if (PADDR == a_gctl) begin
      rdata_nxt = {30'h0, global_irq_enable_r, 1'b0};
    end else if (PADDR == a_pstat) begin
      rdata_nxt = {29'h0, pres_s2_r, resend_r, fatal_r};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      rdata_r <= spfis_pkg::RST_WORD;
    end else if (rd_acc) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign PRDATA = rdata_r;

endmodule

`default_nettype wire

// [tb/spfis_port_events_asserts.sv]
// checker: timing properties of the port event block, bound to its top
`timescale 1ns/10ps
`default_nettype none
// ==========
// checker
module spfis_port_events_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic                   SYS_CLK,
  input wire logic                   RESET_N,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [ADDR_W-1:0]      PADDR,
  input wire logic [31:0]            PRDATA,
  input wire spfis_pkg::spfis_evt_t  EVT,
  input wire spfis_pkg::spfis_diag_t DIAG,
  input wire logic                   PORT_RESET,
  input wire logic [31:0]            FRAME_AREA_BASE,
  input wire logic [31:0]            FRAME_AREA_END,
  input wire logic                   DMA_FATAL,
  input wire logic                   FRAME_RESEND,
  input wire logic                   PORT_START
);
  logic rd_flg;
  logic fat_evt;
  // read access phase of the flag register, and any fatal cause
  assign rd_flg = PSEL && PENABLE && !PWRITE && PADDR == spfis_pkg::OFS_EVENT_FLAGS;
  assign fat_evt = EVT.sync_escape_tx || EVT.data_frame_err || EVT.prd_zero_count ||
                   EVT.prd_overflow || (EVT.unknown_frame_good && EVT.unknown_frame_len > 8'd64);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  property p_base;
    FRAME_AREA_BASE[7:0] == 8'h00 && FRAME_AREA_END == FRAME_AREA_BASE + 32'h000000ff;
  endproperty
  a_base: assert property (p_base) else $error("frame area bounds wrong");
  property p_base_rd;
    PSEL && PENABLE && !PWRITE && PADDR == spfis_pkg::OFS_FRAME_BASE |-> PRDATA[7:0] == 8'h00;
  endproperty
  a_base_rd: assert property (p_base_rd) else $error("base low byte read nonzero");
  property p_fat_set;
    fat_evt && !PORT_RESET |-> ##[1:2] DMA_FATAL;
  endproperty
  a_fat_set: assert property (p_fat_set) else $error("dma not frozen");
  property p_fat_hold;
    DMA_FATAL && PORT_START && !PORT_RESET |=> DMA_FATAL;
  endproperty
  a_fat_hold: assert property (p_fat_hold) else $error("dma freeze dropped");
  property p_fat_rel;
    PORT_RESET && !fat_evt && !$past(fat_evt) |=> !DMA_FATAL;
  endproperty
  a_fat_rel: assert property (p_fat_rel) else $error("port reset kept freeze");
  property p_resend;
    EVT.nondata_frame_err && !PORT_RESET |=> FRAME_RESEND;
  endproperty
  a_resend: assert property (p_resend) else $error("no frame resend");
  property p_rsvd;
    rd_flg |-> PRDATA[28] == 1'b0 && PRDATA[25] == 1'b0 && PRDATA[21:8] == 14'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag bits nonzero");
  property p_mirror;
    rd_flg |-> PRDATA[22] == $past(DIAG.phy_ready_change_diag) &&
      PRDATA[6] == $past(DIAG.connect_change_diag);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror flags differ");
endmodule
bind spfis_port_events spfis_port_events_chk #(.ADDR_W(ADDR_W)) i_spfis_port_events_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .EVT(EVT), .DIAG(DIAG), .PORT_RESET(PORT_RESET),
  .FRAME_AREA_BASE(FRAME_AREA_BASE), .FRAME_AREA_END(FRAME_AREA_END),
  .DMA_FATAL(DMA_FATAL), .FRAME_RESEND(FRAME_RESEND), .PORT_START(PORT_START));
`default_nettype wire

// [tb/spfis_dev_model.sv]
// drive-side model: one event pulse per request, presence pin toggling
`timescale 1ns/10ps
`default_nettype none
module spfis_dev_model (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                go,
  input  wire logic [4:0]          kind,
  input  wire logic [7:0]          len,
  input  wire logic                tf_err,
  output var spfis_pkg::spfis_evt_t evt,
  output var logic                 pres
);
  always_ff @(posedge clk) begin
    evt <= '0;
    if (!rst_n) begin
      pres <= 1'b0;
    end else if (go) begin
      evt.taskfile_status <= {7'h00, tf_err};
      evt.unknown_frame_len <= len;
      case (kind)
        5'd0: evt.presence_toggle <= 1'b1;
        5'd1: evt.taskfile_update <= 1'b1;
        5'd2: evt.bus_error_resp <= 1'b1;
        5'd3: evt.sync_escape_tx <= 1'b1;
        5'd4: evt.data_frame_err <= 1'b1;
        5'd5: evt.nondata_frame_err <= 1'b1;
        5'd6: evt.unknown_frame_good <= 1'b1;
        5'd7: evt.prd_zero_count <= 1'b1;
        5'd8: evt.prd_underflow <= 1'b1;
        5'd9: evt.prd_overflow <= 1'b1;
        5'd10: evt.pm_field_mismatch <= 1'b1;
        5'd11: evt.d2h_irq_posted <= 1'b1;
        5'd12: evt.sdb_irq_posted <= 1'b1;
        5'd13: evt.dma_setup_irq_posted <= 1'b1;
        5'd14: evt.pio_setup_irq_posted <= 1'b1;
        5'd15: evt.prd_irq_done <= 1'b1;
        5'd16: evt.unknown_frame_posted <= 1'b1;
        default: pres <= ~pres; // insertion or removal
      endcase
    end
  end
endmodule
`default_nettype wire

// [tb/test_sata_port_fis_base_and_irq_status.sv]
// bench: register, event flag, interrupt and dma freeze scenarios
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_sata_port_fis_base_and_irq_status;
  logic        clk, rst_n, psel, pen, pwr, go, tf, prst, pready, fatal, intrq, pres;
  logic        serr, se;
  logic [11:0] pa;
  logic [31:0] pwd, prd, q, base;
  logic [4:0]  kind;
  logic [7:0]  len;
  spfis_pkg::spfis_evt_t  evt;
  spfis_pkg::spfis_diag_t diag;
  int          num_errors, comparisons;
  spfis_port_events i_spfis_port_events (.SYS_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prd),
    .PREADY(pready), .PSLVERR(serr), .EVT(evt), .DIAG(diag), .PRESENCE_PIN(pres),
    .PORT_RESET(prst), .FRAME_AREA_BASE(base), .FRAME_AREA_END(), .DMA_FATAL(fatal),
    .FRAME_RESEND(), .PORT_START(), .INTRQ(intrq));
  spfis_dev_model i_spfis_dev_model (.clk(clk), .rst_n(rst_n), .go(go), .kind(kind),
    .len(len), .tf_err(tf), .evt(evt), .pres(pres));
  // ==========
  // bus tasks and expectations
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      finish_test();
    end
    q = prd;
    se = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fire(input logic [4:0] k);
    kind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic fat(logic [4:0] k, logic [7:0] l);
    return k inside {5'd3, 5'd4, 5'd7, 5'd9} || (k == 5'd6 && l > 8'd64);
  endfunction
  function automatic logic [31:0] expf(logic [4:0] k, logic [7:0] l, logic t, c,
                                       logic [1:0] dg);
    logic [31:0] e;
    e = {9'h000, dg[1], 15'h0000, dg[0], 6'h00};
    case (k)
      5'd0, 5'd17: e[31] = c;
      5'd1: e[30] = t;
      5'd2: e[29] = 1'b1;
      5'd5, 5'd8: e[26] = 1'b1;
      5'd9: e[24] = 1'b1;
      5'd10: e[23] = 1'b1;
      5'd11: e[0] = 1'b1;
      5'd12: e[3] = 1'b1;
      5'd13: e[2] = 1'b1;
      5'd14: e[1] = 1'b1;
      5'd15: e[5] = 1'b1;
      5'd16: e[4] = 1'b1;
      default: e[27] = fat(k, l);
    endcase
    return e;
  endfunction
  task automatic run(input logic [4:0] k, input logic [7:0] l, input logic t, c, g,
                     input logic [1:0] dg);
    logic [31:0] e;
    e = expf(k, l, t, c, dg);
    diag <= '0;
    apb(1'b1, spfis_pkg::OFS_PORT_CTRL, 32'h00000000);
    apb(1'b0, spfis_pkg::OFS_PORT_STAT, 32'h00000000);
    `CHK("fatal_clr", q[0], 1'b0)
    apb(1'b1, spfis_pkg::OFS_PORT_CTRL, {30'h00000000, c, 1'b1});
    apb(1'b1, spfis_pkg::OFS_GLOBAL_CTRL, {30'h00000000, g, 1'b0});
    diag <= {dg, 1'b1};
    apb(1'b1, spfis_pkg::OFS_EVENT_FLAGS, 32'hffffffff);
    len <= l;
    tf <= t;
    fire(k);
    repeat (4) @(posedge clk);
    apb(1'b0, spfis_pkg::OFS_EVENT_FLAGS, 32'h00000000);
    `CHK("flags", q, e)
    `CHK("intrq", intrq, g && e != 32'h00000000)
    `CHK("fatal", fatal, fat(k, l))
    apb(1'b1, spfis_pkg::OFS_EVENT_FLAGS, e);
    apb(1'b0, spfis_pkg::OFS_EVENT_FLAGS, 32'h00000000);
    `CHK("w1c", q, e & spfis_pkg::MIRROR_MASK)
    if (fat(k, l) && c) begin
      prst <= 1'b1;
      @(posedge clk);
      prst <= 1'b0;
      apb(1'b0, spfis_pkg::OFS_PORT_STAT, 32'h00000000);
      `CHK("fatal_prst", q[0], 1'b0)
      `CHK("fatal_prst_pin", fatal, 1'b0)
    end
  endtask
  // ==========
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    logic [31:0] w;
    {rst_n, psel, pen, pwr, go, tf, prst, kind, len, pa, pwd} = '0;
    diag = '0;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(32'h1679));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, spfis_pkg::OFS_FRAME_BASE, 32'h00000000);
    `CHK("base_rst", q, 32'h00000000)
    apb(1'b0, spfis_pkg::OFS_EVENT_FLAGS, 32'h00000000);
    `CHK("flags_rst", q, 32'h00000000)
    apb(1'b1, spfis_pkg::OFS_EVENT_ENAB, 32'hffffffff);
    apb(1'b0, spfis_pkg::OFS_EVENT_ENAB, 32'h00000000);
    `CHK("enab", q, spfis_pkg::LIVE_MASK)
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'hffffffff : $urandom;
      apb(1'b1, spfis_pkg::OFS_FRAME_BASE, w);
      apb(1'b1, 12'h020, 32'h00000000);
      `CHK("slverr", se, 1'b1)
      apb(1'b0, spfis_pkg::OFS_FRAME_BASE, 32'h00000000);
      `CHK("base", q, {w[31:8], 8'h00})
      `CHK("slverr_ok", se, 1'b0)
      `CHK("base_out", base, {w[31:8], 8'h00})
    end
    apb(1'b0, 12'h020, 32'h00000000);
    `CHK("unmapped", q, 32'h00000000)
    run(5'd6, 8'd64, 1'b1, 1'b1, 1'b1, 2'd0);
    run(5'd6, 8'd65, 1'b1, 1'b1, 1'b0, 2'd3);
    run(5'd1, 8'd0, 1'b0, 1'b1, 1'b1, 2'd0);
    // each of the 18 event kinds once, with cold detect and global interrupt enabled
    for (int k = 0; k < 18; k++)
      run(5'(k), 8'($urandom), 1'($urandom), 1'b1, 1'b1, 2'($urandom));
    for (int i = 0; i < 40; i++)
      run(5'($urandom % 18), 8'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
          2'($urandom));
    // event in the very cycle of its clearing write
    apb(1'b1, spfis_pkg::OFS_EVENT_FLAGS, 32'hffffffff);
    fork
      fire(5'd2);
      apb(1'b1, spfis_pkg::OFS_EVENT_FLAGS, 32'hffffffff);
    join
    apb(1'b0, spfis_pkg::OFS_EVENT_FLAGS, 32'h00000000);
    `CHK("collide", q[29], 1'b1)
    finish_test();
  end
endmodule
`default_nettype wire
